// File: include/acdr_params.svh
/*
 * Constants of the conversion-result readout block: frame layout, timing counts
 * and reset values.
 * Assumes it is included by bare name from the package file only.
 */
`ifndef ACDR_PARAMS_SVH
`define ACDR_PARAMS_SVH

// ------------------------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------------------------
`define ACDR_FRAME_BITS      40
`define ACDR_BYTE_BITS       8
`define ACDR_DATA24_BYTES    3
`define ACDR_DATA16_BYTES    2
`define ACDR_NOHDR_MSB_FALL  8
`define ACDR_HDR_MSB_FALL    16
`define ACDR_CRC_POLY        8'h07
`define ACDR_CRC_INIT        8'h00
`define ACDR_PAD_BYTE        8'h00

// ------------------------------------------------------------------------------
// Clipping codes
// ------------------------------------------------------------------------------
`define ACDR_POS_FULL_SCALE  24'h7fffff
`define ACDR_NEG_FULL_SCALE  24'h800000

// ------------------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------------------
`define ACDR_CORE_PERIOD_NS  20
`define ACDR_MOD_PERIOD_NS   100
`define ACDR_STBY_CYCLES     3

// ------------------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------------------
`define ACDR_RST_READY_N     1'b1
`define ACDR_RST_WORD        40'h0000000000

`endif

// File: include/acdr_pkg.sv
/*
 * Types shared by the conversion-result readout block.
 * Assumes acdr_params.svh is on the include path.
 */
`include "acdr_params.svh"

package acdr_pkg;

    typedef enum logic [1:0] {
        ACDR_CTL_SYNC,
        ACDR_CTL_START_STOP,
        ACDR_CTL_ONE_SHOT
    } acdr_ctl_mode_e;

    typedef enum logic [1:0] {
        ACDR_PIN_FIXED_DATA,
        ACDR_PIN_AUTO,
        ACDR_PIN_AUTO_DRIVEN,
        ACDR_PIN_RESERVED
    } acdr_pin_mode_e;

    typedef enum logic [1:0] {
        ACDR_RS_IDLE,
        ACDR_RS_LOW,
        ACDR_RS_HOLDOFF,
        ACDR_RS_STBY
    } acdr_rdy_state_e;

    typedef logic [`ACDR_FRAME_BITS-1:0] acdr_frame_t;

endpackage : acdr_pkg

// File: logic/acdr_readout.sv
/*
 * Serial readout of buffered conversion results, the active-low result ready
 * output and the dual-function output pin.
 * Assumes the conversion engine delivers a result pulse with a wide signed value
 * on core_clk_i, that a command decoder elsewhere supplies register read data,
 * and that the host SPI controller drives cs_n_i and sclk_i.
 */
// Contract
// - Host lowers chip select and clocks; result shifts out without any command.
// - Result stays buffered until the next ready falling edge.
// - Same result may be read any number of times until the next one.
// - After a register read command frame, register data replaces the result.
// - Sync and start/stop modes: ready rises at eighth fall of MSB data byte.
// - One-shot mode: ready stays low through read until a new conversion starts.
// - Output check byte covers every preceding output byte, header included.
// - Read aborted after eighth MSB-byte edge still raises ready, clears status bit.
// - Reads starting before ready fall give old result, after it the new one.
// - Two's complement, sign first, 24 or 16 bits by resolution select.
// - Out-of-range input clips to full-scale codes; extended range scaled upstream.
// - Ready goes high at conversion start or resync, low when result available.
// - Standby enabled: ready returns high three master clocks after falling.
// - Unread result: ready pulses high before next falling edge.
// - Dedicated ready output driven always, regardless of chip select.
// - Auto mode: pin mirrors ready, then data from first rising edge until frame end.
// - Pin mode 01 auto; 10 auto and also driven while chip select high.
// - Before first clock, pin holds previous state in mode 00, else follows ready.
// - Status bit 0 set for new result, cleared after read until next result.
// - Header enabled: each result prefixed by the status register byte.
module acdr_readout #(
    parameter int RAW_WIDTH = 26
) (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rstn_i,
    // Host serial link
    input  wire logic                     sclk_i,
    input  wire logic                     cs_n_i,
    output logic                          dual_function_out_o,
    output logic                          dual_function_out_oe_n_o,
    output logic                          result_ready_n_o,
    // Conversion engine
    input  wire logic                     conv_start_i,
    input  wire logic                     result_valid_i,
    input  wire logic signed [RAW_WIDTH-1:0] result_raw_i,
    // Configuration
    input  wire acdr_pkg::acdr_ctl_mode_e ctl_mode_i,
    input  wire acdr_pkg::acdr_pin_mode_e pin_behaviour_select_i,
    input  wire logic                     standby_after_conversion_i,
    input  wire logic                     resolution_16_i,
    input  wire logic                     status_header_en_i,
    input  wire logic                     output_check_en_i,
    input  wire logic [7:1]               status_upper_i,
    // Register read response
    input  wire logic                     reg_read_pending_i,
    input  wire logic [7:0]               reg_read_data_i,
    // Status
    output logic                          result_new_o
);
    import acdr_pkg::*;

    // The modulator period in core cycles is rounded up, so the hold-off
    // before a commit is never shorter than one modulator cycle.
    localparam int MOD_CYCLES = (`ACDR_MOD_PERIOD_NS + `ACDR_CORE_PERIOD_NS - 1) / `ACDR_CORE_PERIOD_NS;
    localparam logic [7:0] MOD_CNT = 8'(MOD_CYCLES);
    localparam logic [7:0] STBY_CNT = 8'(`ACDR_STBY_CYCLES);

    // --------------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------------
    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `ACDR_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc8_step

    function automatic logic [23:0] clip24(input logic signed [RAW_WIDTH-1:0] v);
        logic signed [RAW_WIDTH-1:0] hi;
        logic signed [RAW_WIDTH-1:0] lo;
        hi = RAW_WIDTH'(signed'(`ACDR_POS_FULL_SCALE));
        lo = -hi - RAW_WIDTH'(1);
        if (v > hi) begin
            return `ACDR_POS_FULL_SCALE;
        end else if (v < lo) begin
            return `ACDR_NEG_FULL_SCALE;
        end
        return v[23:0];
    endfunction : clip24

    // --------------------------------------------------------------------------
    // Reset release
    // --------------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // --------------------------------------------------------------------------
    // Link domain: frame capture, shifting and edge counting
    // --------------------------------------------------------------------------
    acdr_frame_t frame_word;
    acdr_frame_t link_shift;
    logic        link_started;
    logic [5:0]  fall_cnt;
    logic        read_tog;
    logic [5:0]  frame_len;
    logic [5:0]  msb_fall;

    // The frame is taken at the first falling edge; the core changes frame_word
    // whenever no read is in flight, and holds off a commit while one is.
    always_ff @(posedge sclk_i or posedge cs_n_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link_started <= 1'b0;
        end else if (cs_n_i) begin
            link_started <= 1'b0;
        end else begin
            link_started <= 1'b1;
        end
    end

    // Chip select high clears the frame position at once: the serial clock
    // stands still between frames, so no clock edge would ever clear it.
    always_ff @(negedge sclk_i or posedge cs_n_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link_shift <= `ACDR_RST_WORD;
            fall_cnt   <= 6'h00;
        end else if (cs_n_i) begin
            link_shift <= `ACDR_RST_WORD;
            fall_cnt   <= 6'h00;
        end else begin
            link_shift <= (fall_cnt == 6'h00) ? (frame_word << 1) : (link_shift << 1);
            fall_cnt   <= (fall_cnt == 6'h3f) ? fall_cnt : fall_cnt + 6'h01;
        end
    end

    // The read toggle must survive chip select, so it has no clear of its own.
    always_ff @(negedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_tog <= 1'b0;
        end else if (!cs_n_i && (fall_cnt + 6'h01 == msb_fall)) begin
            read_tog <= ~read_tog;
        end
    end


    logic first_bit;
    logic link_data;
    logic link_done;

    // Between the first rising and first falling edge the pin shows the top bit of the captured word.

    assign first_bit = frame_word[`ACDR_FRAME_BITS-1];
    assign link_data = (fall_cnt == 6'h00) ? first_bit : link_shift[`ACDR_FRAME_BITS-1];
    assign link_done = (fall_cnt >= frame_len);

    // --------------------------------------------------------------------------
    // Pin output: a plain mux of flop outputs, since the pin serves two clocks
    // --------------------------------------------------------------------------
    logic hold_bit;

    // The held bit equals the bit last shown, so fixed data mode keeps the
    // pin at its previous state until the next frame clocks.
    always_ff @(negedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_bit <= 1'b0;
        end else if (!cs_n_i) begin
            hold_bit <= (fall_cnt == 6'h00) ? frame_word[`ACDR_FRAME_BITS-2] : link_shift[`ACDR_FRAME_BITS-2];
        end
    end

    always_comb begin
        unique case (pin_behaviour_select_i)
            ACDR_PIN_FIXED_DATA: begin
                dual_function_out_o      = link_started ? link_data : hold_bit;
                dual_function_out_oe_n_o = cs_n_i;
            end
            ACDR_PIN_AUTO: begin
                dual_function_out_o      = (link_started && !link_done) ? link_data : result_ready_n_o;
                dual_function_out_oe_n_o = cs_n_i;
            end
            default: begin
                dual_function_out_o      = (link_started && !link_done) ? link_data : result_ready_n_o;
                dual_function_out_oe_n_o = 1'b0;
            end
        endcase
    end

    // --------------------------------------------------------------------------
    // Crossing of read events and read activity into the core domain
    // --------------------------------------------------------------------------
    logic [2:0] tog_sync;
    logic [1:0] cs_sync;

    logic       read_event;
    logic       link_busy;

    // Two flops settle the toggle; the third keeps the prior value so that
    // each change becomes a single-cycle read event.

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tog_sync <= 3'h0;
            cs_sync  <= 2'h3;
        end else begin
            tog_sync <= {tog_sync[1:0], read_tog};
            cs_sync  <= {cs_sync[0], cs_n_i};
        end
    end

    assign read_event = tog_sync[2] ^ tog_sync[1];
    assign link_busy  = !cs_sync[1];

    // --------------------------------------------------------------------------
    // Result buffer and ready sequencing
    // --------------------------------------------------------------------------
    acdr_rdy_state_e state;
    acdr_rdy_state_e next_state;
    logic [23:0]     pending;
    logic [23:0]     next_pending;
    logic [23:0]     buffer;
    logic [23:0]     next_buffer;
    logic [7:0]      wait_cnt;
    logic [7:0]      next_wait_cnt;

    logic            next_result_ready_n;
    logic            next_result_new;

    // A new result always lifts ready first, so every result gives a fresh
    // falling edge even when the previous one was never read.

    always_comb begin
        next_state          = state;
        next_pending        = pending;
        next_buffer         = buffer;
        next_wait_cnt       = (wait_cnt == 8'h00) ? wait_cnt : wait_cnt - 8'h01;
        next_result_ready_n = result_ready_n_o;
        next_result_new     = result_new_o;
        if (result_valid_i) begin
            next_pending        = clip24(result_raw_i);
            next_state          = ACDR_RS_HOLDOFF;
            next_wait_cnt       = MOD_CNT;
            next_result_ready_n = 1'b1;
        end else begin
            unique case (state)
                ACDR_RS_IDLE: begin
                end
                ACDR_RS_HOLDOFF: begin
                    // Commit waits a modulator cycle and for any frame in flight.
                    if (wait_cnt == 8'h00 && !link_busy) begin
                        next_buffer         = pending;
                        next_result_new     = 1'b1;
                        next_result_ready_n = 1'b0;
                        next_state          = standby_after_conversion_i ? ACDR_RS_STBY : ACDR_RS_LOW;
                        next_wait_cnt       = STBY_CNT - 8'h01;
                    end
                end
                ACDR_RS_STBY: begin
                    if (wait_cnt == 8'h00) begin
                        next_result_ready_n = 1'b1;
                        next_state          = ACDR_RS_IDLE;
                    end
                end
                ACDR_RS_LOW: begin
                end
            endcase
        end
        if (read_event) begin
            next_result_new = 1'b0;
            if (ctl_mode_i != ACDR_CTL_ONE_SHOT && state != ACDR_RS_HOLDOFF) begin
                next_result_ready_n = 1'b1;
            end
        end
        if (result_valid_i || (state == ACDR_RS_HOLDOFF && wait_cnt == 8'h00 && !link_busy)) begin
            next_result_new = (state == ACDR_RS_HOLDOFF) ? 1'b1 : next_result_new;
        end

        // A start or resync overrides every other cause of a ready change.
        if (conv_start_i) begin
            next_result_ready_n = 1'b1;
            next_state          = ACDR_RS_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state            <= ACDR_RS_IDLE;
            pending          <= 24'h000000;
            buffer           <= 24'h000000;
            wait_cnt         <= 8'h00;
            result_ready_n_o <= `ACDR_RST_READY_N;
            result_new_o     <= 1'b0;
        end else begin
            state            <= next_state;
            pending          <= next_pending;
            buffer           <= next_buffer;
            wait_cnt         <= next_wait_cnt;
            result_ready_n_o <= next_result_ready_n;
            result_new_o     <= next_result_new;
        end
    end

    // --------------------------------------------------------------------------
    // Frame assembly: header, data, check byte, left aligned
    // --------------------------------------------------------------------------
    acdr_frame_t next_frame_word;
    logic [5:0]  next_frame_len;
    logic [5:0]  next_msb_fall;
    logic [31:0] body;
    logic [2:0]  body_bytes;
    logic [7:0]  crc;

    logic [7:0]  status_byte;
    logic [23:0] data_field;

    // The frame is built left aligned in the widest layout; shorter frames
    // simply end earlier, and the check byte sits right after the body.

    always_comb begin
        status_byte = {status_upper_i, result_new_o};
        if (reg_read_pending_i) begin
            data_field = {reg_read_data_i, `ACDR_PAD_BYTE, `ACDR_PAD_BYTE};
        end else if (resolution_16_i) begin
            data_field = {buffer[23:8], `ACDR_PAD_BYTE};
        end else begin
            data_field = buffer;
        end
        body_bytes = resolution_16_i ? 3'(`ACDR_DATA16_BYTES) : 3'(`ACDR_DATA24_BYTES);
        if (status_header_en_i) begin
            body       = {status_byte, data_field};
            body_bytes = body_bytes + 3'h1;
        end else begin
            body = {data_field, `ACDR_PAD_BYTE};
        end

        crc = `ACDR_CRC_INIT;
        for (int b = 0; b < 4; b++) begin
            if (3'(b) < body_bytes) begin
                crc = crc8_step(crc, body[31-8*b -: 8]);
            end
        end

        next_frame_word = {body, `ACDR_PAD_BYTE};
        if (output_check_en_i) begin
            next_frame_word = next_frame_word | (acdr_frame_t'(crc) << (`ACDR_FRAME_BITS - 8 - 8 * int'(body_bytes)));
            next_frame_len  = 6'(8 * (int'(body_bytes) + 1));
        end else begin
            next_frame_len = 6'(8 * int'(body_bytes));
        end

        next_msb_fall = status_header_en_i ? 6'(`ACDR_HDR_MSB_FALL) : 6'(`ACDR_NOHDR_MSB_FALL);
    end

    // Frame contents only move while no frame is in flight.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            frame_word <= `ACDR_RST_WORD;
            frame_len  <= 6'h00;
            msb_fall   <= 6'(`ACDR_NOHDR_MSB_FALL);
        end else if (!link_busy) begin
            frame_word <= next_frame_word;
            frame_len  <= next_frame_len;
            msb_fall   <= next_msb_fall;
        end
    end

endmodule : acdr_readout

// File: verification/acdr_host_model.sv
/*
 * Host serial controller that reads result frames without any command.
 * Assumes the bench calls read_frame and wires the dual-function pin to sdo_i.
 */
module acdr_host_model (
    // Serial link
    output logic      sclk_o,
    output logic      cs_n_o,
    input  wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
    end

    // The clock stands low outside frames; no input line exists, so the idle pattern is implied.
    task automatic read_frame(input int nbits, output logic [39:0] word, output logic tail);
        word = '0;
        cs_n_o = 1'b0;
        #40;
        for (int i = 0; i < nbits; i++) begin
            sclk_o = 1'b1;
            #5;
            word = {word[38:0], sdo_i};
            #10;
            sclk_o = 1'b0;
            #15;
        end
        tail = sdo_i;
        #10;
        cs_n_o = 1'b1;
        #100;
    endtask : read_frame
endmodule : acdr_host_model

// File: verification/acdr_readout_monitor.sv
/*
 * Checker of the result readout block, watching its ports only.
 * Assumes acdr_pkg is compiled first and that the bench binds it to acdr_readout.
 */
module acdr_readout_monitor (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rstn_i,
    // Link and pins
    input  wire logic                     cs_n_i,
    input  wire logic                     dual_function_out_o,
    input  wire logic                     dual_function_out_oe_n_o,
    input  wire logic                     result_ready_n_o,
    // Conversion engine and configuration
    input  wire logic                     conv_start_i,
    input  wire logic                     result_valid_i,
    input  wire acdr_pkg::acdr_ctl_mode_e ctl_mode_i,
    input  wire acdr_pkg::acdr_pin_mode_e pin_behaviour_select_i,
    input  wire logic                     standby_after_conversion_i,
    input  wire logic                     result_new_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import acdr_pkg::*;

    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_valid_lifts_ready: assert property (result_valid_i |=> result_ready_n_o)
        else $error("ready stayed low after a new result");
    a_start_lifts_ready: assert property (conv_start_i |=> result_ready_n_o)
        else $error("ready stayed low after a start");
    a_commit_bounded: assert property (
        result_valid_i ##1 (cs_n_i && !result_valid_i && !conv_start_i)[*8] |-> !result_ready_n_o)
        else $error("result not made ready in time");
    a_fall_marks_new: assert property ($fell(result_ready_n_o) |-> result_new_o)
        else $error("ready fell without the new flag");
    a_new_with_fall: assert property ($rose(result_new_o) |-> $fell(result_ready_n_o))
        else $error("new flag rose without ready falling");
    a_standby_pulse: assert property (
        standby_after_conversion_i && $fell(result_ready_n_o) |-> (!result_ready_n_o)[*3] ##1 result_ready_n_o)
        else $error("standby ready pulse is not three cycles");
    a_one_shot_hold: assert property (
        ctl_mode_i == ACDR_CTL_ONE_SHOT && !result_ready_n_o && !conv_start_i && !result_valid_i
        && !standby_after_conversion_i |=> !result_ready_n_o)
        else $error("ready rose in one-shot mode");
    a_oe_follows_cs: assert property (
        pin_behaviour_select_i inside {ACDR_PIN_FIXED_DATA, ACDR_PIN_AUTO} |-> dual_function_out_oe_n_o == cs_n_i)
        else $error("pin enable does not follow chip select");
    a_oe_kept_on: assert property (pin_behaviour_select_i == ACDR_PIN_AUTO_DRIVEN |-> !dual_function_out_oe_n_o)
        else $error("pin released in driven mode");
    a_pin_mirrors: assert property (
        pin_behaviour_select_i == ACDR_PIN_AUTO_DRIVEN && cs_n_i |-> dual_function_out_o == result_ready_n_o)
        else $error("pin does not mirror ready");
endmodule : acdr_readout_monitor

// File: verification/acdr_readout_tb.sv
/*
 * Self-checking bench of the result readout block.
 * Assumes the package, the logic, the host model and the monitor are compiled first.
 */
module acdr_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acdr_pkg::*;

    logic           core_clk_i, rstn_i, sclk, cs_n, pin, pin_oe_n, ready_n, rnew, tail;
    logic           conv_start, valid, stby, res16, hdr, crc, pend;
    logic [25:0]    raw;
    logic [6:0]     st_up;
    logic [7:0]     rdata;
    logic [39:0]    word;
    acdr_ctl_mode_e ctl;
    acdr_pin_mode_e pin_sel;
    int             errors = 0;
    int             checks = 0;
    int             cycles = 0;
    logic [25:0]    clip_in[4]  = '{26'h0ffffff, 26'h3000000, 26'h3ffffff, 26'h07fffff};
    logic [23:0]    clip_out[4] = '{24'h7fffff, 24'h800000, 24'hffffff, 24'h7fffff};

    acdr_readout i_acdr_readout (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .dual_function_out_o(pin), .dual_function_out_oe_n_o(pin_oe_n), .result_ready_n_o(ready_n),
        .conv_start_i(conv_start), .result_valid_i(valid), .result_raw_i(raw), .ctl_mode_i(ctl),
        .pin_behaviour_select_i(pin_sel), .standby_after_conversion_i(stby), .resolution_16_i(res16),
        .status_header_en_i(hdr), .output_check_en_i(crc), .status_upper_i(st_up),
        .reg_read_pending_i(pend), .reg_read_data_i(rdata), .result_new_o(rnew)
    );
    acdr_host_model i_acdr_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdo_i(pin));

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    // ---------------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    task automatic post(input logic [25:0] r, input bit wait_ready);
        raw = r;
        valid = 1'b1;
        tick(1);
        valid = 1'b0;
        if (wait_ready) repeat (40) if (ready_n === 1'b1) tick(1);
    endtask : post

    function automatic logic [39:0] frame_of(input logic [23:0] d, input logic nb, output int n);
        logic [39:0] w;
        logic [7:0]  c;
        w = hdr ? {32'h0, st_up, nb} : 40'h0;
        n = hdr ? 8 : 0;
        w = res16 ? ((w << 16) | 40'(d[23:8])) : ((w << 24) | 40'(d));
        n += res16 ? 16 : 24;
        c = 8'h00;
        for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        if (crc) begin
            w = (w << 8) | 40'(c);
            n += 8;
        end
        return w;
    endfunction : frame_of

    task automatic rd(input logic [23:0] d, input logic nb, input string what);
        logic [39:0] exp;
        logic [39:0] w;
        logic        t;
        int          n;
        exp = frame_of(d, nb, n);
        i_acdr_host_model.read_frame(n, w, t);
        check(w, exp, what);
        if (pin_sel != ACDR_PIN_FIXED_DATA) check(40'(t), 40'(ctl != ACDR_CTL_ONE_SHOT), "pin after frame");
        tick(1);
    endtask : rd

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            wrap_up();
        end
    end

    // ---------------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------------
    initial begin
        {rstn_i, conv_start, valid, stby, res16, hdr, crc, pend} = '0;
        {raw, st_up, rdata} = {26'h0, 7'h2a, 8'ha5};
        ctl = ACDR_CTL_SYNC;
        pin_sel = ACDR_PIN_FIXED_DATA;
        tick(6);
        rstn_i = 1'b1;
        tick(4);
        for (int m = 0; m < 3; m++) begin
            pin_sel = acdr_pin_mode_e'(2'(m));
            post(26'h0123456, 1'b1);
            post(26'h05abcde, 1'b1);
            rd(24'h5abcde, 1'b1, "result word");
            check(40'(ready_n), 40'h1, "ready after read");
            check(40'(rnew), 40'h0, "new flag after read");
            rd(24'h5abcde, 1'b0, "repeat read");
        end
        $display("test plain reads done");
        for (int i = 0; i < 4; i++) begin
            post(clip_in[i], 1'b1);
            rd(clip_out[i], 1'b1, "clipped code");
        end
        $display("test clipping done");
        {hdr, crc, res16} = 3'b111;
        post(26'h0012345, 1'b1);
        rd(24'h012345, 1'b1, "long frame");
        rd(24'h012345, 1'b0, "long frame again");
        {hdr, res16, pend} = 3'b001;
        rd(24'ha50000, 1'b0, "register data");
        pend = 1'b0;
        $display("test long and register frames done");
        {hdr, crc} = 2'b10;
        post(26'h0054321, 1'b1);
        i_acdr_host_model.read_frame(16, word, tail);
        tick(2);
        check(40'(ready_n), 40'h1, "ready after abort");
        check(40'(rnew), 40'h0, "new flag after abort");
        rd(24'h054321, 1'b0, "read after abort");
        post(26'h0022222, 1'b0);
        rd(24'h054321, 1'b0, "old result in hold-off");
        repeat (40) if (ready_n === 1'b1) tick(1);
        rd(24'h022222, 1'b1, "new result after hold-off");
        $display("test abort and hold-off done");
        ctl = ACDR_CTL_ONE_SHOT;
        post(26'h0011111, 1'b1);
        rd(24'h011111, 1'b1, "one-shot read");
        check(40'(ready_n), 40'h0, "ready held in one-shot");
        conv_start = 1'b1;
        tick(1);
        conv_start = 1'b0;
        tick(1);
        check(40'(ready_n), 40'h1, "ready after start");
        ctl = ACDR_CTL_START_STOP;
        stby = 1'b1;
        post(26'h0033333, 1'b1);
        tick(4);
        check(40'(ready_n), 40'h1, "ready after standby pulse");
        check(40'(rnew), 40'h1, "new flag kept");
        rd(24'h033333, 1'b1, "standby read");
        stby = 1'b0;
        $display("test control modes done");
        wrap_up();
    end
endmodule : acdr_readout_tb

bind acdr_readout acdr_readout_monitor i_acdr_readout_monitor (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .dual_function_out_o(dual_function_out_o),
    .dual_function_out_oe_n_o(dual_function_out_oe_n_o), .result_ready_n_o(result_ready_n_o),
    .conv_start_i(conv_start_i), .result_valid_i(result_valid_i), .ctl_mode_i(ctl_mode_i),
    .pin_behaviour_select_i(pin_behaviour_select_i), .standby_after_conversion_i(standby_after_conversion_i),
    .result_new_o(result_new_o)
);
